// ===== arc_top.sv
// Result, status and control logic of a converter behind an APB slave.
// Assumes the analog front end holds conv_data steady at completion.
`timescale 1ns/10ps

module arc_top #(
	parameter int CONV_TICKS = arc_pkg::CONV_TICKS_DEF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Converter front end
	input wire logic conv_clk_async,
	input wire logic [11:0] conv_data,
	output logic [4:0] conv_channel,
	output logic conv_active,
	// Interrupt
	output logic irq
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	generate
		if (CONV_TICKS < 1 || CONV_TICKS > 255) begin : g_bad_ticks
			$error("CONV_TICKS must lie in 1..255");
		end
	endgenerate

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	arc_pkg::arc_state_t state;
	logic [7:0] tick_cnt;
	logic [4:0] ctl_channel;
	logic ctl_cont;
	logic ctl_aien;
	logic [1:0] cfg_mode;
	logic cfg_async;
	logic conversion_complete_flag;
	logic [11:0] result;
	logic [7:0] lo_hold;
	logic lo_frozen;
	logic [1:0] int_status;
	logic [1:0] int_mask;
	logic async_q;
	logic async_prev;
	logic [11:0] data_q;
	logic tick;
	logic wr_acc;
	logic rd_setup;
	logic sc1_wr;
	logic start;
	logic last_tick;
	logic done;
	logic done_ok;
	logic hi_rd;
	logic lo_rd;
	logic wide_mode;
	logic cfg_wr;
	logic stat_wr;
	logic mask_wr;
	logic mode_ok;
	logic [1:0] stat_clr;
	logic [1:0] stat_set;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Right-justify the 12-bit sample for the chosen resolution
	function automatic logic [11:0] justify(input logic [1:0] mode, input logic [11:0] raw);
		logic [11:0] r;
		r = 12'h000;
		case (mode)
			arc_pkg::ARC_MODE_12: r = raw;
			arc_pkg::ARC_MODE_10: r = {2'b00, raw[11:2]};
			default: r = {4'h0, raw[11:4]};
		endcase
		return r;
	endfunction

	// Decoded address is valid
	function automatic logic mapped(input logic [7:0] a);
		logic m;
		m = 1'b0;
		case (a)
			arc_pkg::OFF_SC1,
			arc_pkg::OFF_CFG,
			arc_pkg::OFF_RES_HI,
			arc_pkg::OFF_RES_LO,
			arc_pkg::OFF_INT_STAT,
			arc_pkg::OFF_INT_MASK: m = 1'b1;
			default: m = 1'b0;
		endcase
		return m;
	endfunction

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	arc_sync #(
		.W(1)
	) u_clk_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(conv_clk_async),
		.q(async_q)
	);

	arc_sync #(
		.W(12)
	) u_data_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(conv_data),
		.q(data_q)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			async_prev <= 1'b0;
		end else begin
			async_prev <= async_q;
		end
	end

	// Async clock must run below half the bus rate to be seen
	assign tick = cfg_async ? (async_q & ~async_prev) : 1'b1;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign wr_acc = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign sc1_wr = wr_acc & (paddr == arc_pkg::OFF_SC1);
	assign start = sc1_wr & (pwdata[4:0] != arc_pkg::CH_OFF);
	assign wide_mode = (cfg_mode != arc_pkg::ARC_MODE_8);
	// Read effects act at the setup edge, with the same snapshot as prdata
	assign hi_rd = rd_setup & (paddr == arc_pkg::OFF_RES_HI) & wide_mode;
	assign lo_rd = rd_setup & (paddr == arc_pkg::OFF_RES_LO);
	assign pready = psel & penable;
	// Register write strobes
	assign cfg_wr = wr_acc & (paddr == arc_pkg::OFF_CFG);
	assign stat_wr = wr_acc & (paddr == arc_pkg::OFF_INT_STAT);
	assign mask_wr = wr_acc & (paddr == arc_pkg::OFF_INT_MASK);
	// Guards the resolution against the unused code
	assign mode_ok = (pwdata[arc_pkg::CFG_MODE_LSB +: 2] != 2'b11);

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	assign last_tick = (tick_cnt == 8'(CONV_TICKS - 1));
	assign done = (state == arc_pkg::ARC_CONV) & tick & last_tick;
	// A write landing with the finish discards that conversion
	assign done_ok = done & ~sc1_wr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= arc_pkg::ARC_IDLE;
			tick_cnt <= 8'h00;
		end else begin
			unique case (state)
				arc_pkg::ARC_IDLE: begin
					if (start) begin
						state <= arc_pkg::ARC_CONV;
						tick_cnt <= 8'h00;
					end
				end
				arc_pkg::ARC_CONV: begin
					if (sc1_wr) begin
						state <= start ? arc_pkg::ARC_CONV : arc_pkg::ARC_IDLE;
						tick_cnt <= 8'h00;
					end else if (tick) begin
						if (last_tick) begin
							// Single mode parks until software restarts
							state <= ctl_cont ? arc_pkg::ARC_CONV : arc_pkg::ARC_IDLE;
							tick_cnt <= 8'h00;
						end else begin
							tick_cnt <= tick_cnt + 8'h01;
						end
					end
				end
				default: begin
					state <= arc_pkg::ARC_IDLE;
					tick_cnt <= 8'h00;
				end
			endcase
		end
	end

	assign conv_active = (state == arc_pkg::ARC_CONV);
	assign conv_channel = ctl_channel;

	// ----------------------------------------
	// Control and configuration registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_channel <= arc_pkg::CH_RST;
			ctl_cont <= 1'b0;
			ctl_aien <= 1'b0;
		end else if (sc1_wr) begin
			ctl_channel <= pwdata[arc_pkg::SC1_CH_LSB +: arc_pkg::CH_W];
			ctl_cont <= pwdata[arc_pkg::SC1_CONT_BIT];
			ctl_aien <= pwdata[arc_pkg::SC1_AIEN_BIT];
		end
	end

	// Mode code 3 is not a resolution and is ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_mode <= arc_pkg::ARC_MODE_8;
			cfg_async <= 1'b0;
		end else if (cfg_wr) begin
			if (mode_ok) begin
				cfg_mode <= pwdata[arc_pkg::CFG_MODE_LSB +: 2];
			end
			cfg_async <= pwdata[arc_pkg::CFG_ASYNC_BIT];
		end
	end

	// ----------------------------------------
	// Complete flag and result
	// ----------------------------------------
	// Control write beats a same-cycle finish
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conversion_complete_flag <= 1'b0;
		end else if (sc1_wr) begin
			conversion_complete_flag <= 1'b0;
		end else if (done) begin
			conversion_complete_flag <= 1'b1;
		end
	end

	// Only a finished conversion ever replaces the result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result <= 12'h000;
		end else if (done_ok) begin
			result <= justify(cfg_mode, data_q);
		end
	end

	// ----------------------------------------
	// Lower byte coherency
	// ----------------------------------------
	// Captures the value before any same-edge result update
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lo_hold <= 8'h00;
			lo_frozen <= 1'b0;
		end else if (hi_rd) begin
			lo_hold <= result[7:0];
			lo_frozen <= 1'b1;
		end else if (lo_rd || !wide_mode) begin
			lo_frozen <= 1'b0;
		end
	end

	// ----------------------------------------
	// Interrupt status and mask
	// ----------------------------------------
	// Overrun marks a result landing while the flag is still up
	assign stat_clr = stat_wr ? pwdata[arc_pkg::INT_W-1:0] : 2'b00;
	assign stat_set = {done_ok & conversion_complete_flag, done_ok};

	// Hardware set wins over the write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status <= 2'b00;
		end else begin
			int_status <= (int_status & ~stat_clr) | stat_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_mask <= arc_pkg::INT_MASK_RST;
		end else if (mask_wr) begin
			int_mask <= pwdata[arc_pkg::INT_W-1:0];
		end
	end

	assign irq = (conversion_complete_flag & ctl_aien) | (|(int_status & int_mask));

	// ----------------------------------------
	// Read data and error response
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= ~mapped(paddr);
			prdata <= 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					arc_pkg::OFF_SC1: begin
						prdata[arc_pkg::SC1_CH_LSB +: arc_pkg::CH_W] <= ctl_channel;
						prdata[arc_pkg::SC1_CONT_BIT] <= ctl_cont;
						prdata[arc_pkg::SC1_AIEN_BIT] <= ctl_aien;
						prdata[arc_pkg::SC1_FLAG_BIT] <= conversion_complete_flag;
					end
					arc_pkg::OFF_CFG: begin
						prdata[arc_pkg::CFG_MODE_LSB +: 2] <= cfg_mode;
						prdata[arc_pkg::CFG_ASYNC_BIT] <= cfg_async;
					end
					arc_pkg::OFF_RES_HI: begin
						// Upper byte is empty in 8-bit mode
						prdata[3:0] <= wide_mode ? result[11:8] : 4'h0;
					end
					arc_pkg::OFF_RES_LO: begin
						prdata[7:0] <= (wide_mode && lo_frozen) ? lo_hold : result[7:0];
					end
					arc_pkg::OFF_INT_STAT: prdata[1:0] <= int_status;
					arc_pkg::OFF_INT_MASK: prdata[1:0] <= int_mask;
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule

// ===== arc_pkg.sv
// Constants, offsets and types of the converter result and status block.
// Assumes a 32-bit APB register bus and a 12-bit converter front end.
package arc_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_SC1 = 8'h00;
	localparam logic [7:0] OFF_CFG = 8'h04;
	localparam logic [7:0] OFF_RES_HI = 8'h08;
	localparam logic [7:0] OFF_RES_LO = 8'h0C;
	localparam logic [7:0] OFF_INT_STAT = 8'h10;
	localparam logic [7:0] OFF_INT_MASK = 8'h14;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SC1_CH_LSB = 0;
	localparam int SC1_CONT_BIT = 5;
	localparam int SC1_AIEN_BIT = 6;
	localparam int SC1_FLAG_BIT = 7;
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_ASYNC_BIT = 2;
	localparam int INT_DONE_BIT = 0;
	localparam int INT_OVR_BIT = 1;

	// ----------------------------------------
	// Widths, reset values and counts
	// ----------------------------------------
	localparam int CH_W = 5;
	localparam int RES_W = 12;
	localparam int INT_W = 2;
	localparam logic [4:0] CH_OFF = 5'h1f;
	localparam logic [4:0] CH_RST = 5'h1f;
	localparam logic [INT_W-1:0] INT_MASK_RST = 2'h0;
	localparam int CONV_TICKS_DEF = 20;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ARC_MODE_8 = 2'b00,
		ARC_MODE_12 = 2'b01,
		ARC_MODE_10 = 2'b10
	} arc_mode_t;

	typedef enum logic [1:0] {
		ARC_IDLE = 2'b01,
		ARC_CONV = 2'b10
	} arc_state_t;

endpackage

// ===== arc_sync.sv
// Two-stage synchroniser for levels entering the bus clock domain.
// Assumes each bit is a slow level or is stable while it is used.
`timescale 1ns/10ps
module arc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end

endmodule

// ===== arc_fe_model.sv
// Front end model: sample-and-hold data and a gated converter clock.
// Assumes the bench sets the sample while no completion is due.
`timescale 1ns/10ps
module arc_fe_model (
	// Clock
	input wire logic pclk,
	// Control
	input wire logic conv_active,
	input wire logic async_en,
	input wire logic [11:0] sample,
	// Outputs
	output logic conv_clk_async,
	output logic [11:0] conv_data
);
	logic [1:0] div = 2'h0;
	// Runs at a quarter of pclk only while converting with async_en set, still otherwise
	always_ff @(posedge pclk) begin
		div <= (conv_active && async_en) ? div + 2'h1 : 2'h0;
	end
	assign conv_clk_async = div[1];
	assign conv_data = sample;
endmodule

// ===== arc_top_sva.sv
// Checker on the ports of the converter result and status block.
// Assumes a single bus clock domain; bound into arc_top.
`timescale 1ns/10ps
module arc_top_sva #(
	parameter int CONV_TICKS = 20
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Converter and interrupt
	input wire logic [4:0] conv_channel,
	input wire logic conv_active,
	input wire logic irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [1:0] mask_h;
	logic aien_h;
	logic cont_h;
	wire wr_sc1 = psel && penable && pwrite && paddr == arc_pkg::OFF_SC1;
	// Shadow of mask and control bits, from writes only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_h <= 2'h0;
		end else if (psel && penable && pwrite && paddr == arc_pkg::OFF_INT_MASK) begin
			mask_h <= pwdata[1:0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aien_h <= 1'b0;
			cont_h <= 1'b0;
		end else if (wr_sc1) begin
			aien_h <= pwdata[6];
			cont_h <= pwdata[5];
		end
	end
	property p_rdy;
		pready == (psel && penable);
	endproperty
	a_rdy: assert property (p_rdy) else $error("pready wrong");
	property p_start;
		wr_sc1 && pwdata[4:0] != 5'h1f |=> conv_active && conv_channel == $past(pwdata[4:0]);
	endproperty
	a_start: assert property (p_start) else $error("start wrong");
	property p_stop;
		wr_sc1 && pwdata[4:0] == 5'h1f |=> !conv_active && conv_channel == 5'h1f;
	endproperty
	a_stop: assert property (p_stop) else $error("stop wrong");
	property p_err;
		psel && !penable && paddr[1:0] == 2'h0 |=> pslverr == ($past(paddr) > 8'h14);
	endproperty
	a_err: assert property (p_err) else $error("pslverr wrong");
	property p_stand;
		!(psel && !penable) |=> $stable(prdata) && $stable(pslverr);
	endproperty
	a_stand: assert property (p_stand) else $error("read data moved");
	// Single mode must finish on its own; bound covers the async clock too
	property p_single;
		wr_sc1 && pwdata[4:0] != 5'h1f && !pwdata[5] |-> ##[1:300] !conv_active;
	endproperty
	a_single: assert property (p_single) else $error("single never ends");
	property p_irq_off;
		wr_sc1 && !pwdata[6] && mask_h == 2'h0 |=> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq after clear");
	property p_irq_on;
		$fell(conv_active) && aien_h && !cont_h && !$past(wr_sc1) |-> ##[0:2] irq;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq missing");
	c_irq: cover property ($rose(irq));
	c_err: cover property (psel && penable && pslverr);
	c_start: cover property (wr_sc1 && conv_active);
endmodule
bind arc_top arc_top_sva #(.CONV_TICKS(CONV_TICKS)) u_arc_top_sva (.*);

// ===== testbench.sv
// Self-checking bench of the converter block over APB.
// Assumes CONV_TICKS of 2 and a front end model with held samples.
`timescale 1ns/10ps
module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, async_en = 0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, conv_clk_async, conv_active, irq;
	logic [11:0] conv_data, sample = 12'h0;
	logic [4:0] conv_channel;
	logic [15:0] lf = 16'h0025;
	int n_errors = 0, checked = 0, mres, mode, i;
	arc_top #(.CONV_TICKS(2)) u_arc_top (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.conv_clk_async(conv_clk_async), .conv_data(conv_data), .conv_channel(conv_channel),
		.conv_active(conv_active), .irq(irq)
	);
	arc_fe_model u_arc_fe_model (
		.pclk(pclk), .conv_active(conv_active), .async_en(async_en), .sample(sample),
		.conv_clk_async(conv_clk_async), .conv_data(conv_data)
	);
	initial forever #2 pclk = ~pclk;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic int just(input logic [11:0] r, input int m);
		if (m == 0) return r >> 4;
		if (m == 2) return r >> 2;
		return r;
	endfunction
	task final_report;
		$display("checked %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task pin(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask
	// No release at the end, so a following setup can come at once
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		penable <= 0;
	endtask
	task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk(nm, e, rdat);
	endtask
	task idle(input int n);
		psel <= 0;
		repeat (n) @(posedge pclk);
	endtask
	task wirq;
		psel <= 0;
		for (int k = 0; k < 400; k++) begin
			@(posedge pclk);
			if (irq === 1'b1) break;
		end
	endtask
	task newsmp;
		lf = lfsr(lf);
		sample <= lf[11:0];
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		final_report;
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		rd("sc1_rst", 8'h00, 32'h1f);
		rd("mask_rst", 8'h14, 32'h0);
		pin("irq_rst", 0, irq);
		$display("test reset done");
		for (i = 0; i < 4; i++) begin
			mode = (i == 3) ? 1 : i;
			newsmp;
			async_en <= (i == 3);
			apb(1, 8'h04, {29'h0, i == 3, mode[1:0]});
			apb(1, 8'h00, 32'h43);
			mres = just(lf[11:0], mode);
			wirq;
			pin("irq_done", 1, irq);
			rd("sc1_done", 8'h00, 32'hc3);
			chk("chan", 32'h3, {27'h0, conv_channel});
			if (mode == 0) begin
				rd("lo_8", 8'h0c, mres);
			end else begin
				rd("hi", 8'h08, mres >> 8);
				rd("lo", 8'h0c, mres & 255);
			end
			apb(1, 8'h00, 32'h1f);
			rd("sc1_clr", 8'h00, 32'h1f);
			pin("irq_clr", 0, irq);
		end
		$display("test modes done");
		newsmp;
		idle(40);
		rd("hold_hi", 8'h08, mres >> 8);
		rd("hold_lo", 8'h0c, mres & 255);
		apb(1, 8'h04, 32'h1);
		async_en <= 0;
		apb(1, 8'h00, 32'h25);
		idle(20);
		mres = lf[11:0];
		rd("frz_hi", 8'h08, mres >> 8);
		newsmp;
		idle(30);
		rd("frz_lo", 8'h0c, mres & 255);
		mres = lf[11:0];
		rd("new_hi", 8'h08, mres >> 8);
		rd("new_lo", 8'h0c, mres & 255);
		apb(1, 8'h00, 32'h1f);
		$display("test freeze done");
		for (i = 0; i < 3; i++) begin
			newsmp;
			apb(1, 8'h00, 32'h03);
			if (i > 0) idle(i);
			apb(1, 8'h00, 32'h5f);
			rd("race_sc1", 8'h00, 32'h5f);
			pin("race_irq", 0, irq);
		end
		apb(1, 8'h00, 32'h1f);
		$display("test race done");
		apb(1, 8'h14, 32'h1);
		rd("mask", 8'h14, 32'h1);
		pin("stat_irq", 1, irq);
		rd("stat", 8'h10, 32'h3);
		apb(1, 8'h10, 32'h3);
		rd("stat_clr", 8'h10, 32'h0);
		pin("w1c_irq", 0, irq);
		apb(1, 8'h04, 32'h3);
		rd("cfg_ign", 8'h04, 32'h1);
		newsmp;
		apb(1, 8'h00, 32'h07);
		mres = lf[11:0];
		wirq;
		pin("mask_irq", 1, irq);
		apb(1, 8'h14, 32'h0);
		idle(2);
		pin("masked", 0, irq);
		apb(1, 8'h08, 32'hfff);
		rd("ro_hi", 8'h08, mres >> 8);
		rd("bad", 8'h20, 32'h0);
		pin("slverr", 1, pslverr);
		$display("test irq done");
		final_report;
	end
endmodule
